// ===== dac_serial_write_pkg.sv
package dac_serial_write_pkg;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS     = 16;
    localparam int CODE_BITS      = 12;
    localparam int MODE_BITS      = 2;
    localparam int MODE_MSB       = 15;
    localparam int MODE_LSB       = 14;
    localparam int CODE_MSB       = 13;
    localparam int CODE_LSB       = 2;
    localparam logic [3:0] LAST_BIT_INDEX = 4'hF;

    // operating modes carried in the two top frame bits
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_PD_1K    = 2'h1;
    localparam logic [1:0] MODE_PD_100K  = 2'h2;
    localparam logic [1:0] MODE_PD_OPEN  = 2'h3;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL   = 5'h0;
    localparam logic [4:0] OFS_STATUS = 5'h4;
    localparam logic [4:0] OFS_CODE   = 5'h8;
    localparam logic [4:0] OFS_MODE   = 5'hC;

    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int STAT_BUSY_BIT    = 1;
    localparam int STAT_UPDATED_BIT = 0;
    localparam int STAT_ABORTED_BIT = 2;

    localparam logic        CTRL_ENABLE_RESET = 1'b1;
    localparam logic [11:0] CODE_RESET        = 12'h000;
    localparam logic [1:0]  MODE_RESET        = 2'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_SHIFT,
        LINK_DONE
    } link_state_t;

    typedef struct packed {
        logic [MODE_BITS-1:0] mode;
        logic [CODE_BITS-1:0] code;
    } dac_setting_t;

endpackage

// ===== dac_serial_write_port.sv
// How it works
// - a frame opens only on a falling edge of the frame sync line
// - while sync is low, data is shifted in on each serial clock fall
// - on the 16th clock fall the frame updates code and mode
// - after the 16th edge a new frame needs a fresh sync fall
// - serial clock up to 30 MHz; host must not exceed it
// - the two top frame bits select normal or one of three power-downs
// - mode 00 normal, 01 1k load, 10 100k load, 11 open output
// - the 12 bits after the mode pair load the converter code
// - the two lowest frame bits are discarded
// - sync rising before the 16th fall aborts the frame
// - an abort clears the shift register, code and mode kept
// - code is unsigned straight binary for the converter
// - reset clears the code to zero until a valid frame arrives
// - power-down modes never alter the stored code
module dac_serial_write_port
    import dac_serial_write_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        RST_I,
    // link pins
    input  wire logic        FRAME_SYNC_N_I,
    input  wire logic        SERIAL_CLK_I,
    input  wire logic        SERIAL_DATA_IN_I,
    // converter side
    output logic [11:0]      CODE_O,
    output logic [1:0]       MODE_O,
    output logic             POWER_DOWN_O,
    output logic             UPDATE_O,
    // classic wishbone slave
    input  wire logic [4:0]  ADR_I,
    input  wire logic [31:0] DAT_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        WE_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    output logic [31:0]      DAT_O,
    output logic             ACK_O
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // the serial clock is sampled, so its high and low phases must each
    // last over two system clocks; faster links are out of reach
    logic [1:0]   fs_sync;
    logic [1:0]   sck_sync;
    logic [1:0]   sdi_sync;
    logic         fs_q;
    logic         sck_q;

    always_ff @(posedge MCLK_I)
    begin
        fs_sync  <= {fs_sync[0], FRAME_SYNC_N_I};
        sck_sync <= {sck_sync[0], SERIAL_CLK_I};
        sdi_sync <= {sdi_sync[0], SERIAL_DATA_IN_I};
    end

    wire logic fs_s  = fs_sync[1];
    wire logic sck_s = sck_sync[1];
    wire logic sdi_s = sdi_sync[1];

    // edge history, reset high so no false edge appears at release
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            fs_q  <= 1'b1;
            sck_q <= 1'b1;
        end
        else
        begin
            fs_q  <= fs_s;
            sck_q <= sck_s;
        end
    end

    wire logic fs_fall  = fs_q & ~fs_s;
    wire logic sck_fall = sck_q & ~sck_s;

    // ------------------------------------------------------------
    // frame receiver
    // ------------------------------------------------------------
    link_state_t   state;
    logic [15:0]   shreg;
    logic [3:0]    bit_count;
    dac_setting_t  setting;
    logic          enable;
    logic          updated;
    logic          aborted;

    // first bit enters at bit 0 and walks up to the top
    wire logic [15:0] shifted    = {shreg[14:0], sdi_s};
    wire logic        start      = (state == LINK_IDLE) & fs_fall & enable;
    wire logic        abort      = (state == LINK_SHIFT) & fs_s;
    wire logic        take_bit   = (state == LINK_SHIFT) & ~fs_s & sck_fall;
    wire logic        last_bit   = take_bit & (bit_count == LAST_BIT_INDEX);
    wire logic        frame_done = (state == LINK_DONE) & fs_s;

    // low two frame bits never reach the setting
    wire dac_setting_t next_setting = '{
        mode: shifted[MODE_MSB:MODE_LSB],
        code: shifted[CODE_MSB:CODE_LSB]
    };

    // sequencing: only a sync fall opens, only a sync rise closes
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
            state <= LINK_IDLE;
        else
        begin
            case (state)
                LINK_IDLE:
                    if (start)
                        state <= LINK_SHIFT;
                LINK_SHIFT:
                    if (abort)
                        state <= LINK_IDLE;
                    else if (last_bit)
                        state <= LINK_DONE;
                LINK_DONE:
                    if (frame_done)
                        state <= LINK_IDLE;
                default:
                    state <= LINK_IDLE;
            endcase
        end
    end

    // shift register and bit counter
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I || start || abort)
        begin
            shreg     <= '0;
            bit_count <= '0;
        end
        else if (take_bit)
        begin
            shreg     <= shifted;
            bit_count <= bit_count + 4'h1;
        end
    end

    // the setting changes only on a completed frame
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            setting  <= '{mode: MODE_RESET, code: CODE_RESET};
            UPDATE_O <= 1'b0;
        end
        else
        begin
            UPDATE_O <= last_bit;
            if (last_bit)
                setting <= next_setting;
        end
    end

    // straight binary code passes unchanged to the converter
    assign CODE_O       = setting.code;
    assign MODE_O       = setting.mode;
    assign POWER_DOWN_O = (setting.mode != MODE_NORMAL);

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    // one compare per register, shared by every decode below
    function automatic logic addr_hit(input logic [4:0] adr,
                                      input logic [4:0] ofs);
        return adr == ofs;
    endfunction

    // one wait state: ack rises the cycle after the request, drops after
    wire logic       req     = CYC_I & STB_I;
    wire logic       wr_take = req & WE_I & ACK_O;
    wire logic       hit_ctl = addr_hit(ADR_I, OFS_CTRL);
    wire logic       hit_st  = addr_hit(ADR_I, OFS_STATUS);
    wire logic       hit_cd  = addr_hit(ADR_I, OFS_CODE);
    wire logic       hit_md  = addr_hit(ADR_I, OFS_MODE);
    wire logic       lane0   = SEL_I[0];
    wire logic       clr_upd = wr_take & hit_st & lane0
                             & DAT_I[STAT_UPDATED_BIT];
    wire logic       clr_abt = wr_take & hit_st & lane0
                             & DAT_I[STAT_ABORTED_BIT];
    wire logic [2:0] status  = {aborted, state == LINK_SHIFT, updated};

    // unmapped offsets read as zero and ignore writes
    wire logic [31:0] rd_mux =
          hit_ctl ? 32'(enable)
        : hit_st  ? 32'(status)
        : hit_cd  ? 32'(setting.code)
        : hit_md  ? 32'(setting.mode)
        : 32'h0000_0000;

    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end
        else
        begin
            ACK_O <= req & ~ACK_O;
            if (req & ~ACK_O)
                DAT_O <= rd_mux;
        end
    end

    // control: the enable gates whether new frames are opened
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
            enable <= CTRL_ENABLE_RESET;
        else if (wr_take & hit_ctl & lane0)
            enable <= DAT_I[CTRL_ENABLE_BIT];
    end

    // sticky flags, write one to clear; a new event wins over the clear
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            updated <= 1'b0;
            aborted <= 1'b0;
        end
        else
        begin
            updated <= last_bit | (updated & ~clr_upd);
            aborted <= abort | (aborted & ~clr_abt);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);

    a_frame_open: assert property (
        start |=> (state == LINK_SHIFT) && (bit_count == 4'h0)
              && (shreg == 16'h0000))
        else $error("frame did not open on sync fall");

    a_bit_shift: assert property (
        (take_bit && !last_bit) |=> shreg == $past(shifted))
        else $error("serial bit not shifted in");

    a_apply_last: assert property (
        last_bit |=> UPDATE_O && (state == LINK_DONE))
        else $error("sixteenth fall did not apply frame");

    a_code_mode_load: assert property (
        last_bit |=> setting == $past(next_setting))
        else $error("code or mode not taken from frame");

    a_wait_fresh: assert property (
        (state == LINK_DONE && !fs_s) |=> state == LINK_DONE)
        else $error("left done state without sync rise");

    a_abort_keeps: assert property (
        abort |=> $stable(setting) && (shreg == 16'h0000)
              && (state == LINK_IDLE) && !UPDATE_O)
        else $error("aborted frame changed the setting");

    a_only_frame_upd: assert property (
        !$stable(setting) |-> UPDATE_O && ($past(state) == LINK_SHIFT))
        else $error("setting changed outside a frame end");

    a_powerdown_map: assert property (
        POWER_DOWN_O == (MODE_O != MODE_NORMAL))
        else $error("power-down flag disagrees with mode");

    a_ack_single: assert property (
        ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");

    // bus answer and control register
    a_ack_answer: assert property (
        (req && !ACK_O) |=> ACK_O)
        else $error("bus request not answered next cycle");

    a_unmapped_zero: assert property (
        (req && !ACK_O && !WE_I && ADR_I[4]) |=> DAT_O == 32'h0000_0000)
        else $error("unmapped offset did not read zero");

    a_enable_set: assert property (
        (wr_take && hit_ctl && lane0 && DAT_I[CTRL_ENABLE_BIT]) |=> enable)
        else $error("enable write did not land");

    a_enable_clear: assert property (
        (wr_take && hit_ctl && lane0 && !DAT_I[CTRL_ENABLE_BIT])
            |=> !enable)
        else $error("disable write did not land");

    // frame accounting and flags
    a_update_pulse: assert property (
        UPDATE_O |=> !UPDATE_O)
        else $error("update pulse longer than one cycle");

    a_sixteen_bits: assert property (
        (state == LINK_DONE) |-> (bit_count == 4'h0))
        else $error("frame closed without sixteen bits");

    a_update_flag: assert property (
        last_bit |=> updated)
        else $error("updated flag not set by a frame");

    a_abort_flag: assert property (
        abort |=> aborted && (bit_count == 4'h0))
        else $error("aborted flag not set by early sync rise");

    a_done_silent: assert property (
        (state == LINK_DONE) |=> !UPDATE_O && $stable(setting))
        else $error("extra clock falls changed the setting");

    a_shift_gated: assert property (
        !(take_bit || start || abort)
            |=> $stable(shreg) && $stable(bit_count))
        else $error("shift register moved outside a frame");

    a_disabled_idle: assert property (
        (state == LINK_IDLE && !enable) |=> (state == LINK_IDLE))
        else $error("frame opened while the port is disabled");

    // reset value and power-down
    a_reset_code: assert property (
        $past(RST_I) |-> (CODE_O == CODE_RESET) && (MODE_O == MODE_RESET))
        else $error("code not cleared by reset");

    a_pd_keeps_code: assert property (
        (POWER_DOWN_O && !UPDATE_O) |-> $stable(CODE_O))
        else $error("power-down disturbed the stored code");

    c_full_frame:  cover property (last_bit ##1 UPDATE_O);
    c_abort:       cover property (abort);
    c_power_down:  cover property ($rose(POWER_DOWN_O));
    c_bus_read:    cover property (req && !WE_I && ACK_O && hit_cd);
    c_disabled:    cover property (fs_fall && !enable && state == LINK_IDLE);

endmodule

// ===== dac_host_model.sv
module dac_host_model
(
    output logic sync_n_o,
    output logic sclk_o,
    output logic serial_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // idle: sync high, clock parked high between frames
    // ------------------------------------------------------------
    initial
    begin
        sync_n_o      <= 1'b1;
        sclk_o        <= 1'b1;
        serial_data_o <= 1'b0;
    end

    // sends nbits from the top of d; hold leaves sync low afterwards
    task automatic send(input logic [23:0] d, input int nbits,
                        input bit hold);
        // called on a rising edge; non-blocking keeps the pins race free
        sync_n_o <= 1'b1;
        #100 sync_n_o <= 1'b0;
        #100;
        for (int i = 0; i < nbits; i++)
        begin
            serial_data_o <= d[23-i];
            #80 sclk_o <= 1'b0;
            #80 sclk_o <= 1'b1;
        end
        // a released data line must not keep looking valid
        serial_data_o <= ~serial_data_o;
        #80 sync_n_o <= ~hold;
        #200;
    endtask
endmodule

// ===== dac_serial_write_port_bench.sv
module dac_serial_write_port_bench;
    import dac_serial_write_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sync_n, sclk, serial_data, pd, upd, ack, we, cyc, stb;
    logic [11:0] code;
    logic [1:0]  mode;
    logic [4:0]  adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat, q;
    logic [3:0]  sel = '0;
    logic [15:0] w;
    int          err_total = 0;
    int          n_tests = 0;
    int          n_upd = 0;

    // ------------------------------------------------------------
    // clock, parts and pulse counter
    // ------------------------------------------------------------
    initial
    begin
        forever #10 clk = ~clk;
    end
    initial
    begin
        we = 1'b0; cyc = 1'b0; stb = 1'b0;
    end
    dac_host_model HOST (.sync_n_o(sync_n), .sclk_o(sclk),
        .serial_data_o(serial_data));
    dac_serial_write_port DUT (.MCLK_I(clk), .RST_I(rst),
        .FRAME_SYNC_N_I(sync_n), .SERIAL_CLK_I(sclk),
        .SERIAL_DATA_IN_I(serial_data), .CODE_O(code), .MODE_O(mode),
        .POWER_DOWN_O(pd), .UPDATE_O(upd), .ADR_I(adr), .DAT_I(wdat),
        .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(rdat),
        .ACK_O(ack));
    // one count per update pulse shows that no frame applies twice
    always @(posedge clk)
    begin
        if (upd === 1'b1) n_upd++;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [4:0] a, input logic wr,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        adr <= a;
        we <= wr;
        wdat <= d;
        sel <= 4'hF;
        cyc <= 1'b1;
        stb <= 1'b1;
        // hold until ack is seen; only the watchdog ends a hang
        do
        begin
            @(posedge clk);
        end
        while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // outputs must match the frame f and the expected pulse count
    task automatic expect_out(input logic [15:0] f, input int u);
        check({pd, mode, code}, {f[15:14] != 2'h0, f[15:2]});
        check(n_upd, u);
        wb(OFS_CODE, 1'b0, 32'h0000_0000, q);
        check(q, {20'h0_0000, f[13:2]});
    endtask
    task automatic results;
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 500 us
    initial
    begin
        #500_000;
        err_total++;
        results();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        expect_out(16'h0000, 0);
        wb(OFS_CTRL, 1'b0, 32'h0000_0000, q);
        check(q, 32'h0000_0001);
        wb(5'h10, 1'b1, 32'hFFFF_FFFF, q);
        wb(5'h10, 1'b0, 32'h0000_0000, q);
        check(q, 32'h0000_0000);
        // every mode, low two bits set so that dropping them is seen
        for (int m = 0; m < 4; m++)
        begin
            w = {m[1:0], 12'hFFF >> (m * 3), 2'h3};
            HOST.send({w, 8'h00}, 16, 1'b0);
            expect_out(w, m + 1);
        end
        wb(OFS_STATUS, 1'b0, 32'h0000_0000, q);
        check(q, 32'h0000_0001);
        wb(OFS_STATUS, 1'b1, 32'h0000_0005, q);
        // abort after ten bits keeps code and mode
        HOST.send(24'h00_0000, 10, 1'b0);
        expect_out(w, 4);
        wb(OFS_STATUS, 1'b0, 32'h0000_0000, q);
        check(q, 32'h0000_0004);
        // extra edges with sync held low are ignored
        HOST.send(24'h5A_5FFF, 20, 1'b1);
        expect_out(16'h5A5F, 5);
        HOST.send(24'h81_2000, 16, 1'b0);
        expect_out(16'h8120, 6);
        // disabled port ignores a whole frame
        wb(OFS_CTRL, 1'b1, 32'h0000_0000, q);
        HOST.send(24'hC3_3000, 16, 1'b0);
        expect_out(16'h8120, 6);
        wb(OFS_CTRL, 1'b1, 32'h0000_0001, q);
        HOST.send(24'h00_0400, 16, 1'b0);
        expect_out(16'h0004, 7);
        results();
    end
endmodule
